// ===== design/nff_pkg.sv
package nff_pkg;

   // Default geometry: data width and address width (depth is two to the address width).
   localparam int DEF_DATA_W = 8;
   localparam int DEF_ADDR_W = 4;

   // Extra words held by the look-ahead output pipeline beyond the storage array.
   localparam int LA_EXTRA_WORDS = 2;

   // Extra read cycles before empty clears in look-ahead mode after a first write.
   localparam int LA_EMPTY_LAG = 2;

   // Bit positions of the four handshaking flags in the shared flag vector.
   localparam int HS_W = 4;
   localparam int HS_ACK = 0;
   localparam int HS_OVF = 1;
   localparam int HS_VLD = 2;
   localparam int HS_UNF = 3;

   // Default build options for the handshaking flags: all present, all active high.
   localparam logic [HS_W-1:0] HS_PRESENT_DEF = 4'hf;
   localparam logic [HS_W-1:0] HS_HIGH_DEF = 4'hf;

   // Write-side status flags.
   typedef struct packed {
      logic full;
      logic almost_full;
   } nff_wr_flags_s;

   // Read-side status flags.
   typedef struct packed {
      logic empty;
      logic almost_empty;
   } nff_rd_flags_s;

   // Status values after reset: an empty buffer.
   localparam nff_wr_flags_s WR_FLAGS_RST = '{full: 1'b0, almost_full: 1'b0};
   localparam nff_rd_flags_s RD_FLAGS_RST = '{empty: 1'b1, almost_empty: 1'b1};

endpackage : nff_pkg

// ===== design/nff_store.sv
`timescale 1ns/10ps

// Storage array of the buffer: one write port, one combinational read port.
module nff_store #(
   parameter int DATA_W = nff_pkg::DEF_DATA_W,
   parameter int ADDR_W = nff_pkg::DEF_ADDR_W
) (
   // Clock and enable.
   input wire logic clk,
   input wire logic ce,
   // Write port.
   input wire logic wr_go,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   // Read port.
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // The array has no reset, so words never written read as whatever they power up to.
   always_ff @(posedge clk) begin
      if (ce && wr_go) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // The read is combinational; the caller registers the word where timing needs it.
   assign rd_data = mem[rd_addr];

endmodule : nff_store

// ===== design/nff_fifo.sv
`timescale 1ns/10ps

module nff_fifo #(
   parameter int DATA_W = nff_pkg::DEF_DATA_W,
   parameter int ADDR_W = nff_pkg::DEF_ADDR_W,
   parameter bit LOOKAHEAD = 1'b0,
   parameter logic [nff_pkg::HS_W-1:0] HS_PRESENT = nff_pkg::HS_PRESENT_DEF,
   parameter logic [nff_pkg::HS_W-1:0] HS_HIGH = nff_pkg::HS_HIGH_DEF
) (
   // Clock, clock enable and reset.
   input wire logic clk,
   input wire logic ce,
   input wire logic rst,
   // Write side.
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   output logic full,
   output logic almost_full,
   output logic wr_ack,
   output logic overflow,
   // Read side.
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   output logic empty,
   output logic almost_empty,
   output logic rd_valid,
   output logic underflow
);

   localparam int DEPTH = 1 << ADDR_W;
   localparam int CNT_W = ADDR_W + 1;
   localparam int TOT_W = ADDR_W + 2;
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] CNT_AFULL = CNT_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [TOT_W-1:0] TOT_ONE = TOT_W'(1);

   // Level driven on a handshaking output: inactive when the flag is not built.
   function automatic logic hs_level(input logic present, input logic high, input logic active);
      logic lvl;
      lvl = high ? active : ~active;
      if (!present) begin
         lvl = ~high;
      end
      return lvl;
   endfunction : hs_level

   // Storage pointers, fill count and the status registers.
   logic [ADDR_W-1:0] wr_ptr_r;
   logic [ADDR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   nff_pkg::nff_wr_flags_s wr_flags_r;
   nff_pkg::nff_rd_flags_s core_flags_r;
   nff_pkg::nff_rd_flags_s rd_flags_r;
   nff_pkg::nff_rd_flags_s rd_flags_nxt;

   // Request qualification.
   logic wr_go;
   logic std_rd_go;
   logic core_pop;
   logic [DATA_W-1:0] store_word;

   // Look-ahead output pipeline: a middle slot and the presented slot.
   logic mid_vld_r;
   logic [DATA_W-1:0] mid_data_r;
   logic out_vld_r;
   logic out_vld_nxt;
   logic la_take;
   logic out_adv;
   logic mid_free;
   logic la_pop;
   logic mid_vld_nxt;
   logic [TOT_W-1:0] tot_nxt;

   // Output registers.
   logic [DATA_W-1:0] rd_data_r;
   logic [nff_pkg::HS_W-1:0] hs_raw;
   logic [nff_pkg::HS_W-1:0] hs_r;

   // A write is taken only while a slot is free; full turns it away untouched.
   assign wr_go = wr_en && !wr_flags_r.full;

   // A standard read is taken only while the array holds data.
   assign std_rd_go = !LOOKAHEAD && rd_en && !core_flags_r.empty;

   // Look-ahead handshake: a read takes the presented word, which frees the out slot.
   assign la_take = LOOKAHEAD && rd_en && out_vld_r;
   assign out_adv = !out_vld_r || la_take;
   assign mid_free = !mid_vld_r || out_adv;

   // The array feeds the middle slot first, even when the out slot is free.
   // That fixed path is what costs the two extra cycles before empty clears.
   assign la_pop = LOOKAHEAD && !core_flags_r.empty && mid_free;

   assign core_pop = std_rd_go || la_pop;

   // One driver of the count, so every word written is read out exactly once.
   always_comb begin
      cnt_nxt = cnt_r;
      if (wr_go && !core_pop) begin
         cnt_nxt = cnt_r + CNT_ONE;
      end else if (core_pop && !wr_go) begin
         cnt_nxt = cnt_r - CNT_ONE;
      end
   end

   // Occupancy of the look-ahead pipeline after this edge.
   assign mid_vld_nxt = la_pop || (mid_vld_r && !out_adv);
   assign out_vld_nxt = (mid_vld_r && out_adv) || (out_vld_r && !la_take);
   assign tot_nxt = {1'b0, cnt_nxt} + TOT_W'(mid_vld_nxt) + TOT_W'(out_vld_nxt);

   // Read-side flags seen by the user, per read mode.
   // In standard mode almost-empty stays high while empty, so it matches its value after reset.
   always_comb begin
      if (LOOKAHEAD) begin
         rd_flags_nxt.empty = !out_vld_nxt;
         rd_flags_nxt.almost_empty = (tot_nxt <= TOT_ONE);
      end else begin
         rd_flags_nxt.empty = (cnt_nxt == CNT_ZERO);
         rd_flags_nxt.almost_empty = (cnt_nxt <= CNT_ONE);
      end
   end

   // Handshake events, in the order of the flag vector.
   always_comb begin
      hs_raw = '0;
      hs_raw[nff_pkg::HS_ACK] = wr_go;
      hs_raw[nff_pkg::HS_OVF] = wr_en && wr_flags_r.full;
      if (LOOKAHEAD) begin
         hs_raw[nff_pkg::HS_VLD] = out_vld_nxt;
         hs_raw[nff_pkg::HS_UNF] = rd_en && !out_vld_r;
      end else begin
         hs_raw[nff_pkg::HS_VLD] = std_rd_go;
         hs_raw[nff_pkg::HS_UNF] = rd_en && core_flags_r.empty;
      end
   end

   // The storage array.
   nff_store #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W)
   ) u_store (
      .clk(clk),
      .ce(ce),
      .wr_go(wr_go),
      .wr_addr(wr_ptr_r),
      .wr_data(wr_data),
      .rd_addr(rd_ptr_r),
      .rd_data(store_word)
   );

   // Write pointer advances on each accepted write at the edge that samples it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
      end else if (ce && wr_go) begin
         wr_ptr_r <= wr_ptr_r + ADDR_W'(1);
      end
   end

   // Read pointer advances only on a taken pop; an underflow leaves it alone.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_ptr_r <= '0;
      end else if (ce && core_pop) begin
         rd_ptr_r <= rd_ptr_r + ADDR_W'(1);
      end
   end

   // Fill count. With a single clock both pointers live in one domain, so no
   // pointer ever crosses a clock boundary and every flag is built locally.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end

   // Write-side flags follow the count of the array after this edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_flags_r <= nff_pkg::WR_FLAGS_RST;
      end else if (ce) begin
         wr_flags_r.full <= (cnt_nxt == CNT_FULL);
         wr_flags_r.almost_full <= (cnt_nxt == CNT_AFULL);
      end
   end

   // Array-level empty steers the read logic; in standard mode the user sees it too.
   // A taken write and a taken pop together leave the count, and so these flags, unchanged.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_flags_r <= nff_pkg::RD_FLAGS_RST;
      end else if (ce) begin
         core_flags_r.empty <= (cnt_nxt == CNT_ZERO);
         core_flags_r.almost_empty <= (cnt_nxt <= CNT_ONE);
      end
   end

   // User-visible read-side flags.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_flags_r <= nff_pkg::RD_FLAGS_RST;
      end else if (ce) begin
         rd_flags_r <= rd_flags_nxt;
      end
   end

   // Middle slot of the look-ahead pipeline; unused in standard mode.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mid_vld_r <= 1'b0;
         mid_data_r <= '0;
      end else if (ce) begin
         mid_vld_r <= mid_vld_nxt;
         if (la_pop) begin
            mid_data_r <= store_word;
         end
      end
   end

   // Presented slot of the look-ahead pipeline.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_vld_r <= 1'b0;
      end else if (ce) begin
         out_vld_r <= out_vld_nxt;
      end
   end

   // Read word. Standard mode loads on a taken read, one cycle after the request;
   // look-ahead mode loads whenever the middle slot moves forward.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_r <= '0;
      end else if (ce) begin
         if (std_rd_go) begin
            rd_data_r <= store_word;
         end else if (LOOKAHEAD && mid_vld_r && out_adv) begin
            rd_data_r <= mid_data_r;
         end
      end
   end

   // Handshaking flags, one register each, at the polarity chosen when built.
   // Both the write and read flags run on the one clock of this block.
   genvar gi;
   generate
      for (gi = 0; gi < nff_pkg::HS_W; gi = gi + 1) begin : g_hs
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               hs_r[gi] <= ~HS_HIGH[gi];
            end else if (ce) begin
               hs_r[gi] <= hs_level(HS_PRESENT[gi], HS_HIGH[gi], hs_raw[gi]);
            end
         end
      end
   endgenerate

   // Outputs, each taken straight from its register.
   assign full = wr_flags_r.full;
   assign almost_full = wr_flags_r.almost_full;
   assign empty = rd_flags_r.empty;
   assign almost_empty = rd_flags_r.almost_empty;
   assign rd_data = rd_data_r;
   assign wr_ack = hs_r[nff_pkg::HS_ACK];
   assign overflow = hs_r[nff_pkg::HS_OVF];
   assign rd_valid = hs_r[nff_pkg::HS_VLD];
   assign underflow = hs_r[nff_pkg::HS_UNF];

endmodule : nff_fifo

// ===== tb/nff_fifo_monitor.sv
`timescale 1ns/10ps

// Watches one buffer instance; the figures assume the default active-high handshake flags.
module nff_fifo_monitor #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 4,
   parameter bit LOOKAHEAD = 1'b0
) (
   // Clock, clock enable and reset.
   input wire logic clk,
   input wire logic ce,
   input wire logic rst,
   // Write side.
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic full,
   input wire logic almost_full,
   input wire logic wr_ack,
   input wire logic overflow,
   // Read side.
   input wire logic rd_en,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic empty,
   input wire logic almost_empty,
   input wire logic rd_valid,
   input wire logic underflow
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // A refused write, and the write that takes the last free slot.
   sequence s_wr_refused;
      ce && wr_en && full;
   endsequence
   sequence s_last_slot;
      ce && almost_full && wr_en && !rd_en;
   endsequence

   // Standard-mode checks are gated, since look-ahead adds pipeline latency to the read flags.
   chk_wr_taken: assert property (ce && wr_en && !full |=> wr_ack)
      else $error("accepted write not acknowledged");
   chk_wr_refused: assert property (s_wr_refused |=> overflow && !wr_ack)
      else $error("write while full not refused");
   chk_idle_quiet: assert property (ce && !wr_en |=> !wr_ack && !overflow)
      else $error("write flag without a request");
   chk_last_slot: assert property (s_last_slot |=> full && !almost_full)
      else $error("last free slot did not set full");
   chk_rd_refused: assert property (ce && rd_en && empty && !wr_en |=>
      underflow && (LOOKAHEAD || empty))
      else $error("read while empty not refused");
   chk_std_valid: assert property (!LOOKAHEAD && ce && rd_en && !empty |=>
      rd_valid && !underflow)
      else $error("accepted read without valid");
   chk_one_left: assert property (!LOOKAHEAD && ce && almost_empty && !empty && rd_en &&
      !wr_en |=> empty && rd_valid)
      else $error("last word did not empty the buffer");
   chk_flags_hold: assert property (!LOOKAHEAD && ce && wr_en && rd_en && !empty && !full
      |=> $stable({full, almost_full, empty, almost_empty}))
      else $error("status changed on balanced access");
   chk_empty_write: assert property (!LOOKAHEAD && ce && wr_en && empty |=> !empty)
      else $error("write did not clear empty");
   chk_la_valid: assert property (LOOKAHEAD |-> rd_valid == !empty)
      else $error("look-ahead valid disagrees with empty");
endmodule : nff_fifo_monitor

bind nff_fifo nff_fifo_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LOOKAHEAD(LOOKAHEAD)) u_mon (
   .clk(clk), .ce(ce), .rst(rst), .wr_en(wr_en), .wr_data(wr_data), .full(full),
   .almost_full(almost_full), .wr_ack(wr_ack), .overflow(overflow), .rd_en(rd_en),
   .rd_data(rd_data), .empty(empty), .almost_empty(almost_empty), .rd_valid(rd_valid),
   .underflow(underflow));

// ===== tb/nff_user_model.sv
`timescale 1ns/10ps

// Far-end user logic: keeps the balance of accepted writes against accepted reads.
module nff_user_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Handshake pulses from the buffer.
   input wire logic wr_ack,
   input wire logic rd_valid,
   // Words written but not yet read back.
   output int held
);
   // Standard mode only: a look-ahead valid is a level and would be counted many times.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held <= 0;
      end else begin
         held <= held + int'(wr_ack) - int'(rd_valid);
      end
   end
endmodule : nff_user_model

// ===== tb/native_fifo_flags_read_modes_tb.sv
`timescale 1ns/10ps

module native_fifo_flags_read_modes_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_data;
   logic [7:0] rd_data_la;
   wire logic [7:0] fl;
   wire logic [7:0] la;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int held;
   // Rows: write, read, write word, then flags {full,af,ack,ovf,empty,ae,vld,unf} and read word.
   localparam logic [25:0] ROWS [7] = '{
      {1'h0, 1'h1, 8'h00, 8'h0d, 8'h00}, {1'h1, 1'h1, 8'h11, 8'h25, 8'h00},
      {1'h1, 1'h1, 8'h22, 8'h26, 8'h11}, {1'h1, 1'h0, 8'h33, 8'h20, 8'h11},
      {1'h0, 1'h1, 8'h00, 8'h06, 8'h22}, {1'h0, 1'h1, 8'h00, 8'h0e, 8'h33},
      {1'h0, 1'h1, 8'h00, 8'h0d, 8'h33}};

   // Both read modes see the same stimulus; the clock enable stays on except in the final clock-enable case.
   nff_fifo dut (.clk(clk), .ce(ce), .rst(rst), .wr_en(wr_en), .wr_data(wr_data),
      .full(fl[7]), .almost_full(fl[6]), .wr_ack(fl[5]), .overflow(fl[4]), .rd_en(rd_en),
      .rd_data(rd_data), .empty(fl[3]), .almost_empty(fl[2]), .rd_valid(fl[1]),
      .underflow(fl[0]));
   nff_fifo #(.LOOKAHEAD(1'b1)) dut_la (.clk(clk), .ce(ce), .rst(rst), .wr_en(wr_en),
      .wr_data(wr_data), .full(la[7]), .almost_full(la[6]), .wr_ack(la[5]),
      .overflow(la[4]), .rd_en(rd_en), .rd_data(rd_data_la), .empty(la[3]),
      .almost_empty(la[2]), .rd_valid(la[1]), .underflow(la[0]));
   nff_user_model u_user (.clk(clk), .rst(rst), .wr_ack(fl[5]), .rd_valid(fl[1]), .held(held));

   // Clock generator.
   always #10 clk = ~clk;

   // The run needs about fifty cycles, so a ceiling of a thousand means a hang.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   // Inputs change one step after the edge; results are sampled at the same point.
   task automatic drive(input logic w, input logic r, input logic [7:0] d);
      wr_en = w;
      rd_en = r;
      wr_data = d;
      @(posedge clk);
      #1;
   endtask : drive

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   // Main sequence: reset, table, reset, fill and drain, the look-ahead latency case, then the clock enable case.
   initial begin
      drive(1'b0, 1'b0, 8'h00);
      drive(1'b0, 1'b0, 8'h00);
      rst = 1'b0;
      foreach (ROWS[i]) begin
         drive(ROWS[i][25], ROWS[i][24], ROWS[i][23:16]);
         chk({fl, rd_data}, ROWS[i][15:0]);
      end
      $display("table done");
      rst = 1'b1;
      drive(1'b0, 1'b0, 8'h00);
      chk({fl, la, rd_data}, 24'h0c0c00);
      rst = 1'b0;
      $display("reset done");
      for (int i = 0; i < 17; i++) begin
         drive(1'b1, 1'b0, 8'(i));
         chk(fl[7:4], {i >= 15, i == 14, i <= 15, i == 16});
      end
      for (int j = 0; j < 16; j++) begin
         drive(1'b0, 1'b1, 8'h00);
         chk({rd_data, fl[1], fl[7]}, {8'(j), 2'b10});
      end
      drive(1'b0, 1'b1, 8'h00);
      chk({fl[0], fl[3], held[7:0]}, {2'b11, 8'h00});
      $display("fill and drain done");
      rst = 1'b1;
      drive(1'b0, 1'b0, 8'h00);
      rst = 1'b0;
      drive(1'b1, 1'b0, 8'ha5);
      chk({fl[3], la[3]}, 2'b01);
      drive(1'b0, 1'b0, 8'h00);
      chk(la[3], 1'b1);
      drive(1'b0, 1'b0, 8'h00);
      chk({la[3], la[1], rd_data_la}, {2'b01, 8'ha5});
      drive(1'b0, 1'b1, 8'h00);
      chk({fl[3], fl[1], rd_data, la[3], la[1]}, {2'b11, 8'ha5, 2'b10});
      drive(1'b0, 1'b1, 8'h00);
      chk({fl[0], la[0], la[1]}, 3'b110);
      $display("look-ahead done");
      // A write with the clock enable low must leave every register frozen.
      ce = 1'b0;
      drive(1'b1, 1'b0, 8'h5a);
      chk({fl[5], fl[3], la[5], la[3]}, 4'h5);
      ce = 1'b1;
      drive(1'b0, 1'b0, 8'h00);
      chk({fl[5], fl[3], la[3]}, 3'b011);
      $display("clock enable done");
      end_sim();
   end
endmodule : native_fifo_flags_read_modes_tb
